// [src/ptt_map.svh]
`ifndef PTT_MAP_SVH
`define PTT_MAP_SVH
// ==========================================
// Register byte addresses
`define PTT_ADDR_INDEX      12'h0_520
`define PTT_ADDR_CTRL       12'h0_52c
`define PTT_ADDR_TGT_NS     12'h0_530
`define PTT_ADDR_TGT_S      12'h0_534
`define PTT_ADDR_IRQ_STAT   12'h0_540
`define PTT_ADDR_IRQ_MASK   12'h0_544
// ==========================================
// Control and status field positions
`define PTT_B_OUT_SEL       8
`define PTT_B_PIN_IN        7
`define PTT_B_PIN_DIR       6
`define PTT_B_CAP_IRQ       5
`define PTT_B_TRIG_ACT      4
`define PTT_B_TRIG_EN       3
`define PTT_B_TRIG_RST      2
`define PTT_B_CAP_EN        1
`define PTT_B_CAP_RST       0
// ==========================================
// Index register fields
`define PTT_IDX_TRIG_HI     1
`define PTT_IDX_CAP         8
`define PTT_IDX_PIN         16
// ==========================================
// Status bit positions (shared by status and mask)
`define PTT_S_DONE          0
`define PTT_S_ERR           4
`define PTT_S_CAP           8
// ==========================================
// Widths and counts
`define PTT_NS_W            30
`define PTT_CNT_W           4
`define PTT_CNT_MAX         4'h_f
`define PTT_ZERO32          32'h0000_0000
`define PTT_RESP_OKAY       2'h0
`define PTT_RESP_SLVERR     2'h2
`endif

// [src/ptt_pkg.sv]
package ptt_pkg;
  // ==========================================
  // Types
  typedef enum logic [1:0] {WR_IDLE, WR_RESP} ptt_wr_state_type;
  typedef logic [31:0] ptt_word_type;
endpackage : ptt_pkg

// [src/ptt_event_ctrl.sv]
// Summary of operation
// [RULE1] Index register routes every field access
// [RULE2] Output select picks combinational or flopped
// [RULE3] Bit 7 shows indexed pin input
// [RULE4] Direction bit: capture input or output
// [RULE5] Per-capture-unit interrupt enable bit
// [RULE6] Active bit reads running without error
// [RULE7] Enable starts unit, self-clears on fire
// [RULE8] Software enables only chain head; the code has no chaining and software enables any indexed unit
// [RULE9] Trigger soft reset restores defaults
// [RULE10] Capture enable write zeroes event count
// [RULE11] Capture disable clears ready and overflow
// [RULE12] Capture soft reset restores defaults
// [RULE13] Thirty-bit nanosecond target, top bits zero
// [RULE14] Thirty-two-bit seconds target per unit
// [RULE15] Clearing enable clears trigger error
// [RULE16] Immediate option fires on past target
// [RULE17] Done/error/irq only with notify set
// [RULE18] Compare system time against target
`include "ptt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ptt_event_ctrl
  import ptt_pkg::*;
(
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Synchronous reset, low
  input  wire logic [11:0] s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output var  logic        s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output var  logic        s_axi_wready,  // Write data ready
  output var  logic [1:0]  s_axi_bresp,   // Write response
  output var  logic        s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [11:0] s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output var  logic        s_axi_arready, // Read address ready
  output var  logic [31:0] s_axi_rdata,   // Read data
  output var  logic [1:0]  s_axi_rresp,   // Read response
  output var  logic        s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic [31:0] sys_time_s,    // System time seconds
  input  wire logic [29:0] sys_time_ns,   // System time nanoseconds
  input  wire logic [2:0]  trig_now,      // Per-unit immediate option
  input  wire logic [2:0]  trig_notify,   // Per-unit notify option
  input  wire logic [1:0]  pin_in,        // Pin input levels, async
  output var  logic [1:0]  pin_out,       // Pin output levels
  output var  logic [1:0]  pin_oe,        // Pin drive enables
  output var  logic [1:0]  cap_enable,    // Capture units enabled
  output var  logic [1:0]  cap_irq_en,    // Capture interrupt enables
  output var  logic        irq            // Level interrupt
);

  // ==========================================
  // State
  ptt_wr_state_type          wr_state_reg;
  logic [11:0]               aw_addr_reg;
  logic [31:0]               w_data_reg;
  logic [3:0]                w_strb_reg;
  logic                      aw_have_reg;
  logic                      w_have_reg;
  logic [31:0]               index_reg;
  logic [2:0]                trig_en_reg;
  logic [2:0]                trig_act_reg;
  logic [2:0]                trig_done_reg;
  logic [2:0]                trig_err_reg;
  logic [2:0]                trig_fire_reg;
  logic [`PTT_NS_W-1:0]      tgt_ns_reg [3];
  logic [31:0]               tgt_s_reg [3];
  logic [1:0]                out_sel_reg;
  logic [1:0]                pin_dir_reg;
  logic [1:0]                cap_en_reg;
  logic [1:0]                cap_irq_reg;
  logic [1:0]                cap_rdy_reg;
  logic [1:0]                cap_ovfl_reg;
  logic [`PTT_CNT_W-1:0]     cap_cnt_reg [2];
  logic [1:0]                pin_s1_reg;
  logic [1:0]                pin_s2_reg;
  logic [1:0]                pin_s3_reg;
  logic [1:0]                pin_lvl_reg;
  logic [1:0]                pin_flop_reg;
  logic [31:0]               irq_stat_reg;
  logic [31:0]               irq_mask_reg;

  logic                      wr_go;
  logic                      rd_go;
  logic [31:0]               wmask;
  logic [1:0]                ti;
  logic                      ci;
  logic                      pi;
  logic [2:0]                reach;
  logic [2:0]                fire;
  logic [2:0]                past;
  logic [1:0]                cap_evt;
  logic [31:0]               stat_set;

  // Byte-lane mask from strobes
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  // Merge write data under strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [31:0] m);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  // ==========================================
  // Write channel: address and data in any order
  assign wr_go = aw_have_reg && w_have_reg && wr_state_reg == WR_IDLE;
  assign wmask = lane_mask(w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg  <= WR_IDLE;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 12'h0_000;
      w_data_reg    <= `PTT_ZERO32;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PTT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      unique case (wr_state_reg)
        WR_IDLE: begin
          if (wr_go) begin
            wr_state_reg <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg == `PTT_ADDR_INDEX || aw_addr_reg == `PTT_ADDR_CTRL ||
                             aw_addr_reg == `PTT_ADDR_TGT_NS || aw_addr_reg == `PTT_ADDR_TGT_S ||
                             aw_addr_reg == `PTT_ADDR_IRQ_STAT ||
                             aw_addr_reg == `PTT_ADDR_IRQ_MASK) ? `PTT_RESP_OKAY : `PTT_RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg  <= WR_IDLE;
            s_axi_bvalid  <= 1'b0;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Index pointers
  // [RULE1] Unit selection pointers
  assign ti = index_reg[`PTT_IDX_TRIG_HI:0];
  assign ci = index_reg[`PTT_IDX_CAP];
  assign pi = index_reg[`PTT_IDX_PIN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_reg <= `PTT_ZERO32;
    end else if (wr_go && aw_addr_reg == `PTT_ADDR_INDEX) begin
      index_reg <= merge(index_reg, w_data_reg, wmask);
    end
  end

  // ==========================================
  // Target times; pointer value 3 selects no unit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        tgt_ns_reg[i] <= '0;
        tgt_s_reg[i]  <= `PTT_ZERO32;
      end
    end else if (wr_go && ti != 2'd3) begin
      // [RULE13] Nanosecond target store
      if (aw_addr_reg == `PTT_ADDR_TGT_NS) begin
        tgt_ns_reg[ti] <= `PTT_NS_W'(merge({2'b00, tgt_ns_reg[ti]}, w_data_reg, wmask));
      end
      // [RULE14] Seconds target store
      if (aw_addr_reg == `PTT_ADDR_TGT_S) begin
        tgt_s_reg[ti] <= merge(tgt_s_reg[ti], w_data_reg, wmask);
      end
    end
  end

  // ==========================================
  // Trigger compare
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // [RULE18] Target reached test
      reach[i] = (sys_time_s > tgt_s_reg[i]) ||
                 (sys_time_s == tgt_s_reg[i] && sys_time_ns >= tgt_ns_reg[i]);
      past[i]  = (sys_time_s > tgt_s_reg[i]) ||
                 (sys_time_s == tgt_s_reg[i] && sys_time_ns > tgt_ns_reg[i]);
    end
  end

  // [RULE16] Immediate option gates late fire
  assign fire = trig_act_reg & reach & (trig_now | ~trig_fire_reg);

  // Trigger unit enable, active, done, error. A target already late at
  // enable time either fires at once or, with notify set, is flagged as an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_en_reg   <= 3'b000;
      trig_act_reg  <= 3'b000;
      trig_done_reg <= 3'b000;
      trig_err_reg  <= 3'b000;
      trig_fire_reg <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        trig_fire_reg[i] <= 1'b0;
        if (fire[i]) begin
          // [RULE7] Self-clear on fire
          trig_en_reg[i]   <= 1'b0;
          trig_act_reg[i]  <= 1'b0;
          // [RULE17] Done only with notify
          trig_done_reg[i] <= trig_notify[i];
        end else if (trig_fire_reg[i] && past[i]) begin
          trig_act_reg[i] <= 1'b0;
          // [RULE17] Error only with notify
          trig_err_reg[i] <= trig_notify[i];
        end
      end
      if (wr_go && aw_addr_reg == `PTT_ADDR_CTRL && ti != 2'd3 && w_strb_reg[0]) begin
        if (w_data_reg[`PTT_B_TRIG_RST]) begin
          // [RULE9] Soft reset to defaults
          trig_en_reg[ti]   <= 1'b0;
          trig_act_reg[ti]  <= 1'b0;
          trig_done_reg[ti] <= 1'b0;
          trig_err_reg[ti]  <= 1'b0;
        end else if (w_data_reg[`PTT_B_TRIG_EN]) begin
          // [RULE7] Enable starts unit
          trig_en_reg[ti]   <= 1'b1;
          trig_act_reg[ti]  <= 1'b1;
          trig_fire_reg[ti] <= 1'b1;
          trig_done_reg[ti] <= 1'b0;
        end else begin
          // [RULE15] Disable clears error
          trig_en_reg[ti]  <= 1'b0;
          trig_act_reg[ti] <= 1'b0;
          trig_err_reg[ti] <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // Pin configuration and output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sel_reg <= 2'b00;
      pin_dir_reg <= 2'b00;
    end else if (wr_go && aw_addr_reg == `PTT_ADDR_CTRL && w_strb_reg[1] && w_strb_reg[0]) begin
      out_sel_reg[pi] <= w_data_reg[`PTT_B_OUT_SEL];
      // [RULE4] Direction select
      pin_dir_reg[pi] <= w_data_reg[`PTT_B_PIN_DIR];
    end
  end

  // Pin n carries trigger unit n. The flopped path adds one cycle of
  // latency; the combinational path is then retimed into the output flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_flop_reg <= 2'b00;
      pin_out      <= 2'b00;
      pin_oe       <= 2'b11;
    end else begin
      pin_flop_reg <= fire[1:0];
      for (int i = 0; i < 2; i++) begin
        // [RULE2] Output source select
        pin_out[i] <= out_sel_reg[i] ? fire[i] : pin_flop_reg[i];
        // [RULE4] Drive only as output
        pin_oe[i]  <= ~pin_dir_reg[i];
      end
    end
  end

  // Three-stage synchroniser; a level change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_reg  <= 2'b00;
      pin_s2_reg  <= 2'b00;
      pin_s3_reg  <= 2'b00;
      pin_lvl_reg <= 2'b00;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 2; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_lvl_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  // ==========================================
  // Capture units: pin n feeds capture unit n on rising edges
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cap_evt[i] = cap_en_reg[i] && pin_dir_reg[i] && pin_s2_reg[i] && pin_s3_reg[i] &&
                   !pin_lvl_reg[i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_en_reg   <= 2'b00;
      cap_irq_reg  <= 2'b00;
      cap_rdy_reg  <= 2'b00;
      cap_ovfl_reg <= 2'b00;
      cap_cnt_reg[0] <= '0;
      cap_cnt_reg[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_evt[i]) begin
          cap_rdy_reg[i] <= 1'b1;
          if (cap_cnt_reg[i] == `PTT_CNT_MAX) begin
            cap_ovfl_reg[i] <= 1'b1;
          end else begin
            cap_cnt_reg[i] <= cap_cnt_reg[i] + 1'b1;
          end
        end
      end
      if (wr_go && aw_addr_reg == `PTT_ADDR_CTRL && w_strb_reg[0]) begin
        if (w_data_reg[`PTT_B_CAP_RST]) begin
          // [RULE12] Capture soft reset
          cap_en_reg[ci]   <= 1'b0;
          cap_irq_reg[ci]  <= 1'b0;
          cap_rdy_reg[ci]  <= 1'b0;
          cap_ovfl_reg[ci] <= 1'b0;
          cap_cnt_reg[ci]  <= '0;
        end else begin
          // [RULE5] Interrupt enable per unit
          cap_irq_reg[ci] <= w_data_reg[`PTT_B_CAP_IRQ];
          cap_en_reg[ci]  <= w_data_reg[`PTT_B_CAP_EN];
          if (w_data_reg[`PTT_B_CAP_EN]) begin
            // [RULE10] Enable zeroes count
            cap_cnt_reg[ci] <= '0;
          end else begin
            // [RULE11] Disable clears flags
            cap_rdy_reg[ci]  <= 1'b0;
            cap_ovfl_reg[ci] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================
  // Interrupt status: sticky, cleared by read, set wins over clear
  assign rd_go = s_axi_arvalid && s_axi_arready;
  always_comb begin
    stat_set = `PTT_ZERO32;
    stat_set[`PTT_S_DONE +: 3] = fire & trig_notify;
    stat_set[`PTT_S_ERR +: 3]  = trig_fire_reg & ~fire & past & trig_notify;
    stat_set[`PTT_S_CAP +: 2]  = cap_evt & cap_irq_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= `PTT_ZERO32;
      irq_mask_reg <= `PTT_ZERO32;
      irq          <= 1'b0;
    end else begin
      if (rd_go && s_axi_araddr == `PTT_ADDR_IRQ_STAT) begin
        irq_stat_reg <= stat_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | stat_set;
      end
      if (wr_go && aw_addr_reg == `PTT_ADDR_IRQ_MASK) begin
        irq_mask_reg <= merge(irq_mask_reg, w_data_reg, wmask);
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================
  // Read channel, one cycle after address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `PTT_ZERO32;
      s_axi_rresp   <= `PTT_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `PTT_RESP_OKAY;
      s_axi_rdata   <= `PTT_ZERO32;
      unique case (s_axi_araddr)
        `PTT_ADDR_INDEX: s_axi_rdata <= index_reg;
        `PTT_ADDR_CTRL: begin
          s_axi_rdata[`PTT_B_OUT_SEL]  <= out_sel_reg[pi];
          // [RULE3] Pin level readback
          s_axi_rdata[`PTT_B_PIN_IN]   <= pin_lvl_reg[pi];
          s_axi_rdata[`PTT_B_PIN_DIR]  <= pin_dir_reg[pi];
          s_axi_rdata[`PTT_B_CAP_IRQ]  <= cap_irq_reg[ci];
          // [RULE6] Active without error
          s_axi_rdata[`PTT_B_TRIG_ACT] <= (ti != 2'd3) && trig_act_reg[ti] && !trig_err_reg[ti];
          s_axi_rdata[`PTT_B_TRIG_EN]  <= (ti != 2'd3) && trig_en_reg[ti];
          s_axi_rdata[`PTT_B_CAP_EN]   <= cap_en_reg[ci];
        end
        `PTT_ADDR_TGT_NS: s_axi_rdata <= (ti == 2'd3) ? `PTT_ZERO32 : {2'b00, tgt_ns_reg[ti]};
        `PTT_ADDR_TGT_S: s_axi_rdata <= (ti == 2'd3) ? `PTT_ZERO32 : tgt_s_reg[ti];
        `PTT_ADDR_IRQ_STAT: s_axi_rdata <= irq_stat_reg;
        `PTT_ADDR_IRQ_MASK: s_axi_rdata <= irq_mask_reg;
        default: s_axi_rresp <= `PTT_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Capture state exported for the capture datapath
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_enable <= 2'b00;
      cap_irq_en <= 2'b00;
    end else begin
      cap_enable <= cap_en_reg;
      cap_irq_en <= cap_irq_reg;
    end
  end

endmodule : ptt_event_ctrl
`default_nettype wire

// [verif/ptt_event_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Handshake and pin checks
module ptt_event_ctrl_props (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset, low
  input wire logic        s_axi_awvalid, // AW valid
  input wire logic        s_axi_awready, // AW ready
  input wire logic        s_axi_wvalid,  // W valid
  input wire logic        s_axi_wready,  // W ready
  input wire logic [1:0]  s_axi_bresp,   // B response
  input wire logic        s_axi_bvalid,  // B valid
  input wire logic        s_axi_bready,  // B ready
  input wire logic        s_axi_arvalid, // AR valid
  input wire logic        s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata,   // R data
  input wire logic        s_axi_rvalid,  // R valid
  input wire logic        s_axi_rready,  // R ready
  input wire logic [1:0]  pin_out,       // Pin levels
  input wire logic [1:0]  pin_oe,        // Pin enables
  input wire logic [1:0]  cap_enable,    // Capture enables
  input wire logic        irq            // Interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] wr_hist;
  logic [3:0] bus_hist;
  // ==========================================
  // Recent bus events; register side effects need a cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_hist  <= 4'h0;
      bus_hist <= 4'h0;
    end else begin
      wr_hist  <= {wr_hist[2:0], s_axi_awvalid & s_axi_awready};
      bus_hist <= {bus_hist[2:0], (s_axi_awvalid & s_axi_awready) |
                   (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & s_axi_rready)};
    end
  end
  // Write taken as one step, response one or two cycles later
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_b_time;    s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
  property p_wr_block;  s_wr_take |=> !s_axi_awready && !s_axi_wready; endproperty
  property p_r_time;    s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_pulse;     (|pin_out) |=> !(|(pin_out & $past(pin_out))); endproperty
  property p_oe_cause;  $changed(pin_oe) |-> (|wr_hist); endproperty
  property p_cap_cause; $changed(cap_enable) |-> (|wr_hist); endproperty
  property p_irq_fall;  $fell(irq) |-> (|bus_hist); endproperty
  a_b_time:    assert property (p_b_time) else $error("write response late");
  a_wr_block:  assert property (p_wr_block) else $error("write not blocked");
  a_r_time:    assert property (p_r_time) else $error("read answer late");
  a_r_hold:    assert property (p_r_hold) else $error("read data moved");
  a_b_hold:    assert property (p_b_hold) else $error("write response moved");
  a_pulse:     assert property (p_pulse) else $error("trigger pulse too long");
  a_oe_cause:  assert property (p_oe_cause) else $error("pin enable moved alone");
  a_cap_cause: assert property (p_cap_cause) else $error("capture enable moved alone");
  a_irq_fall:  assert property (p_irq_fall) else $error("interrupt fell alone");
endmodule : ptt_event_ctrl_props
bind ptt_event_ctrl ptt_event_ctrl_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_out,
  .pin_oe, .cap_enable, .irq);
`default_nettype wire

// [verif/test_ptt_event_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ptt_map.svh"
module test_ptt_event_ctrl;
  import ptt_pkg::*;
  localparam logic [11:0] a_ix = `PTT_ADDR_INDEX, a_ct = `PTT_ADDR_CTRL, a_ns = `PTT_ADDR_TGT_NS,
    a_s = `PTT_ADDR_TGT_S, a_st = `PTT_ADDR_IRQ_STAT, a_mk = `PTT_ADDR_IRQ_MASK;
  // ==========================================
  // Bench signals
  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic         s_axi_rready, irq;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, sys_time_s;
  logic [29:0]  sys_time_ns;
  logic [3:0]   s_axi_wstrb;
  logic [2:0]   trig_now, trig_notify;
  logic [1:0]   s_axi_bresp, s_axi_rresp, pin_in, pin_out, pin_oe, cap_enable, cap_irq_en, rr;
  ptt_word_type d;
  int           failures, n_compared, cnt[2];
  int           cyc = 0;
  ptt_event_ctrl dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_time_s, .sys_time_ns, .trig_now,
    .trig_notify, .pin_in, .pin_out, .pin_oe, .cap_enable, .cap_irq_en, .irq
  );
  // Clock, 50 ns period
  always #25 aclk = ~aclk;
  // Ceiling on cycles; a stuck handshake ends here
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      test_done();
    end
  end
  // ==========================================
  // Tasks
  task automatic chk(input ptt_word_type g, input ptt_word_type e, input string m);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input ptt_word_type v, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output ptt_word_type v, output logic [1:0] p);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    p = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [11:0] a, input ptt_word_type e, input string m,
                    input ptt_word_type k = 32'hffff_ffff);
    rd(a, d, rr);
    chk(d & k, e, m);
  endtask : rc
  // Edges until the unit 0 pulse shows, at most 20
  task automatic pw(output int c);
    c = 0;
    while (pin_out[0] !== 1'b1 && c < 20) begin
      @(posedge aclk);
      c++;
    end
  endtask : pw
  task automatic test_done();
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // ==========================================
  // Main sequence
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, trig_now, trig_notify, pin_in, failures, n_compared} = '0;
    sys_time_s  = 32'h0000_000a;
    sys_time_ns = 30'h0000_03e8;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(a_ct, `PTT_ZERO32, "control reset");
    rc(a_ns, `PTT_ZERO32, "ns reset");
    rc(a_s, `PTT_ZERO32, "s reset");
    for (int t = 0; t < 3; t++) begin
      wr(a_ix, ptt_word_type'(t));
      wr(a_ns, 32'hffff_fff0 + t);
      wr(a_s, 32'h0000_0100 + t);
    end
    for (int t = 0; t < 3; t++) begin
      wr(a_ix, ptt_word_type'(t));
      rc(a_ns, 32'h3fff_fff0 + t, "ns target");
      rc(a_s, 32'h0000_0100 + t, "s target");
    end
    wr(a_ix, 32'h0000_0003);
    rc(a_s, `PTT_ZERO32, "unit 3");
    rd(12'h7f0, d, rr);
    chk({30'h0, rr}, {30'h0, `PTT_RESP_SLVERR}, "unmapped resp");
    chk(d, `PTT_ZERO32, "unmapped data");
    wr(12'h7f0, d);
    chk({30'h0, s_axi_bresp}, {30'h0, `PTT_RESP_SLVERR}, "write resp");
    // Pin 1 high, pin 0 low
    pin_in <= 2'b10;
    wr(a_ix, 32'h0001_0000);
    wr(a_ct, `PTT_ZERO32);
    rc(a_ct, 32'h0000_0080, "pin level");
    wr(a_ct, 32'h0000_0040);
    rc(a_ct, 32'h0000_00c0, "direction");
    chk({30'h0, pin_oe}, 32'h0000_0001, "pin enables");
    wr(a_ct, `PTT_ZERO32, 4'h0);
    rc(a_ct, 32'h0000_00c0, "no strobes");
    wr(a_ct, `PTT_ZERO32);
    wr(a_ix, 32'h0000_0100);
    wr(a_ct, 32'h0000_0022);
    rc(a_ct, 32'h0000_0022, "capture on");
    chk({26'h0, pin_oe, cap_enable, cap_irq_en}, 32'h0000_003a, "capture pins");
    wr(a_ct, 32'h0000_0020);
    rc(a_ct, 32'h0000_0020, "capture off");
    chk({26'h0, pin_oe, cap_enable, cap_irq_en}, 32'h0000_0032, "capture off pins");
    wr(a_ct, 32'h0000_0023);
    rc(a_ct, `PTT_ZERO32, "capture reset");
    // Trigger unit 0 on pin 0, both output sources
    wr(a_ix, `PTT_ZERO32);
    wr(a_mk, 32'h0000_0377);
    trig_notify <= 3'h7;
    rd(a_st, d, rr);
    for (int s = 1; s >= 0; s--) begin
      wr(a_ns, 32'h0000_07d0);
      wr(a_s, 32'h0000_000a);
      wr(a_ct, ptt_word_type'(s << 8) | 32'h0000_0008);
      rc(a_ct, ptt_word_type'(s << 8) | 32'h0000_0018, "armed");
      sys_time_ns <= 30'h0000_07d0;
      pw(cnt[s]);
      sys_time_ns <= 30'h0000_03e8;
      rc(a_ct, ptt_word_type'(s << 8), "fired");
      chk({31'h0, irq}, 32'h0000_0001, "irq set");
      rc(a_st, 32'h0000_0001, "done");
      repeat (4) @(posedge aclk);
      chk({31'h0, irq}, `PTT_ZERO32, "irq cleared");
    end
    chk(ptt_word_type'(cnt[1] < 20), 32'h0000_0001, "fire seen");
    chk(ptt_word_type'(cnt[0] - cnt[1]), 32'h0000_0001, "source select");
    // Target in the past: error, then immediate option
    wr(a_s, 32'h0000_0005);
    wr(a_ct, 32'h0000_0008);
    rc(a_ct, `PTT_ZERO32, "late inactive", 32'h0000_0010);
    rc(a_st, 32'h0000_0010, "late error");
    wr(a_ct, `PTT_ZERO32);
    trig_now <= 3'h7;
    wr(a_ct, 32'h0000_0008);
    rc(a_st, 32'h0000_0001, "now fires");
    trig_notify <= 3'h0;
    wr(a_ct, 32'h0000_0008);
    rc(a_ct, `PTT_ZERO32, "quiet fire", 32'h0000_0018);
    rc(a_st, `PTT_ZERO32, "no notify");
    // Soft reset halts an armed unit
    wr(a_s, 32'h0000_0014);
    wr(a_ct, 32'h0000_0008);
    wr(a_ct, 32'h0000_000c);
    rc(a_ct, `PTT_ZERO32, "soft reset", 32'h0000_0018);
    test_done();
  end
endmodule : test_ptt_event_ctrl
`default_nettype wire
